// ### dv/calendar_date_month_counters_bench.sv
`timescale 1ns/10ps
module calendar_date_month_counters_bench;
  logic       sys_clk = 0, resetn, reg_wr, reg_rd, day_tick, year_carry;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, year_bcd, day_of_month, month, v;
  int         mismatches, checked, cyc, seed = 41, d, m, y, cy;
  cdm_date_month dut (.*);
  cdm_host_model host (.*);
  function automatic logic [7:0] bcd(input int x);
    return 8'(x / 10 * 16 + x % 10);
  endfunction
  task automatic chk(input string s, input logic [7:0] e, g);
    checked++;
    mismatches += int'(g !== e);
    if (g !== e) $display("wrong value %s expected %h seen %h", s, e, g);
  endtask
  // reference calendar, one tick
  task step;
    @(negedge sys_clk);
    d = (d >= (m == 2 ? 28 + int'(y % 4 == 0) : m == 4 || m == 6 || m == 9 || m == 11 ? 30 : 31)) ? 1 : d + 1;
    cy = int'(d == 1 && m == 12);
    m = d == 1 ? m % 12 + 1 : m;
    y += cy;
    chk("day", bcd(d), day_of_month);
    chk("month", bcd(m), month);
    chk("carry", 8'(cy), {7'h0, year_carry});
    year_bcd = bcd(y);
  endtask
  task stop_test(input int extra);
    mismatches += extra;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc == 3000) stop_test(1);
  initial
  begin
    {resetn, day_tick, year_bcd, d, m, y} = 0;
    repeat (20) @(negedge sys_clk);
    resetn = 1;
    repeat (6)
    begin
      d = 1 + {$random(seed)} % 28;
      host.xfer(1, 8'h04, bcd(d), v);
      host.xfer(0, 8'h04, 8'h00, v);
      chk("read day", bcd(d), v);
    end
    host.xfer(0, 8'h07, 8'h00, v);
    chk("unmapped", 8'h00, v);
    host.xfer(1, 8'h04, 8'h31, v);
    host.xfer(1, 8'h05, 8'h13, v);
    host.xfer(0, 8'h05, 8'h00, v);
    chk("read month", 8'h13, v);
    day_tick = 1;
    @(negedge sys_clk);
    chk("bad month", 8'h01, month);
    {d, m} = {32'd1, 32'd1};
    repeat (800) step;
    // ticks still running: the write must win on the day register
    host.xfer(1, 8'h04, 8'h25, v);
    chk("write beats tick", 8'h25, day_of_month);
    stop_test(0);
  end
endmodule // calendar_date_month_counters_bench

// ### dv/cdm_date_month_monitor.sv
`timescale 1ns/10ps
module cdm_date_month_monitor (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       reg_wr,
  input wire logic       day_tick,
  input wire logic       year_carry,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] day_of_month,
  input wire logic [7:0] month
);
  wire logic tk = day_tick & ~reg_wr;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_dw; reg_wr && reg_addr == 8'h04 |=> day_of_month == ($past(reg_wdata) & 8'h3f); endproperty
  a_dw: assert property (p_dw) else $error("day write");
  property p_mw; reg_wr && reg_addr == 8'h05 |=> month == ($past(reg_wdata) & 8'h1f); endproperty
  a_mw: assert property (p_mw) else $error("month write");
  property p_dr; tk && day_of_month == 8'h31 |=> day_of_month == 8'h01; endproperty
  a_dr: assert property (p_dr) else $error("day roll");
  property p_mr; tk && month == 8'h12 && day_of_month == 8'h31 |=> month == 8'h01 && year_carry; endproperty
  a_mr: assert property (p_mr) else $error("month roll");
  property p_mu; tk && month == 8'h09 && day_of_month == 8'h30 |=> month == 8'h10; endproperty
  a_mu: assert property (p_mu) else $error("units carry");
  property p_iv; tk && month == 8'h13 && day_of_month == 8'h31 |=> month == 8'h01; endproperty
  a_iv: assert property (p_iv) else $error("bad month");
  property p_rz; day_of_month[7:6] == 2'h0 && month[7:5] == 3'h0; endproperty
  a_rz: assert property (p_rz) else $error("reserved bits");
  cover property (day_tick && reg_wr);
  cover property (year_carry);
  cover property (tk);
  cover property (reg_wr);
endmodule // cdm_date_month_monitor
bind cdm_date_month cdm_date_month_monitor u_mon (.*);

// ### dv/cdm_host_model.sv
`timescale 1ns/10ps
module cdm_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  task xfer(input logic w, input logic [7:0] a, d, output logic [7:0] v);
    @(negedge sys_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge sys_clk);
    {reg_wr, reg_rd, reg_wdata} = {2'b00, ~d};
    v = reg_rdata;
  endtask
endmodule // cdm_host_model

// ### rtl/cdm_date_month.sv
// Operation
// - day-of-month register 0x04, bcd tens/units fields
// - month register 0x05, one tens bit, units
// - day runs 01 to month length
// - month runs 01 to 12
// - month units field is a bcd digit
// - invalid written digits count until next rollover
`timescale 1ns/10ps

module cdm_date_month
  import cdm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       day_tick,
  input  wire logic [7:0] year_bcd,
  output logic            year_carry,
  output logic      [7:0] day_of_month,
  output logic      [7:0] month
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] day_q,        day_d;
  logic [7:0] month_q,      month_d;
  logic [7:0] rdata_q,      rdata_d;
  logic       year_carry_q, year_carry_d;
  logic [7:0] last_day;
  logic       leap_year;
  logic       day_roll;
  logic       month_roll;
  logic       day_wr_hit;
  logic       month_wr_hit;
  logic [3:0] day_units;
  logic [1:0] day_tens;
  logic [3:0] month_units;

  // ----------------------------------------------------------------
  // host write decode
  // ----------------------------------------------------------------
  // a write beats the tick, but only on the register it hits
  assign day_wr_hit   = reg_wr && (reg_addr == DAY_OF_MONTH_COUNT_ADDR);
  assign month_wr_hit = reg_wr && (reg_addr == MONTH_COUNT_ADDR);

  // ----------------------------------------------------------------
  // digit views
  // ----------------------------------------------------------------
  assign day_units   = day_q[DAY_UNITS_MSB:DAY_UNITS_LSB];
  assign day_tens    = day_q[DAY_TENS_MSB:DAY_TENS_LSB];
  assign month_units = month_q[MONTH_UNITS_MSB:MONTH_UNITS_LSB];

  // ----------------------------------------------------------------
  // leap year
  // ----------------------------------------------------------------
  always_comb
  begin
    // year divisible by four, checked digit-wise in bcd; century ignored
    if (year_bcd[4])
    begin
      leap_year = (year_bcd[3:0] == 4'h2) || (year_bcd[3:0] == 4'h6);
    end
    else
    begin
      leap_year = (year_bcd[3:0] == 4'h0) || (year_bcd[3:0] == 4'h4) || (year_bcd[3:0] == 4'h8);
    end
  end

  // ----------------------------------------------------------------
  // month length
  // ----------------------------------------------------------------
  always_comb
  begin
    if (month_q == MONTH_FEB)
      last_day = leap_year ? DAYS_29 : DAYS_28;
    else if ((month_q == MONTH_APR) || (month_q == MONTH_JUN) || (month_q == MONTH_SEP) || (month_q == MONTH_NOV))
      last_day = DAYS_30;
    else
      last_day = DAYS_31;
  end

  // ----------------------------------------------------------------
  // rollover
  // ----------------------------------------------------------------
  // bcd order matches numeric order, so a plain compare finds the end;
  // a day written above the end rolls at the next tick, a month at the next day rollover
  assign day_roll   = (day_q >= last_day);
  assign month_roll = (month_q >= LAST_MONTH);

  // ----------------------------------------------------------------
  // day counter
  // ----------------------------------------------------------------
  always_comb
  begin
    day_d = day_q;
    if (day_tick)
    begin
      if (day_roll)
      begin
        day_d = FIRST_DAY;
      end
      else if (day_units == BCD_NINE)
      begin
        day_d[DAY_UNITS_MSB:DAY_UNITS_LSB] = 4'h0;
        day_d[DAY_TENS_MSB:DAY_TENS_LSB]   = 2'(day_tens + 2'h1);
      end
      else
      begin
        day_d[DAY_UNITS_MSB:DAY_UNITS_LSB] = 4'(day_units + 4'h1);
      end
    end
    if (day_wr_hit)
    begin
      day_d = reg_wdata;
    end
    day_d = day_d & DAY_FIELD_MASK;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      day_q <= DAY_RESET;
    end
    else
    begin
      day_q <= day_d;
    end
  end

  // ----------------------------------------------------------------
  // month counter
  // ----------------------------------------------------------------
  always_comb
  begin
    month_d = month_q;
    if (day_tick && day_roll)
    begin
      if (month_roll)
      begin
        month_d = FIRST_MONTH;
      end
      else if (month_units == BCD_NINE)
      begin
        month_d[MONTH_UNITS_MSB:MONTH_UNITS_LSB] = 4'h0;
        month_d[MONTH_TENS_BIT]                  = 1'b1;
      end
      else
      begin
        // invalid units digits keep counting unchanged in kind
        month_d[MONTH_UNITS_MSB:MONTH_UNITS_LSB] = 4'(month_units + 4'h1);
      end
    end
    if (month_wr_hit)
    begin
      month_d = reg_wdata;
    end
    month_d = month_d & MONTH_FIELD_MASK;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      month_q <= MONTH_RESET;
    end
    else
    begin
      month_q <= month_d;
    end
  end

  // ----------------------------------------------------------------
  // year carry
  // ----------------------------------------------------------------
  always_comb
  begin
    // one-cycle pulse into the year counter on the december rollover
    year_carry_d = day_tick && day_roll && month_roll;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      year_carry_q <= 1'b0;
    end
    else
    begin
      year_carry_q <= year_carry_d;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      case (reg_addr)
        DAY_OF_MONTH_COUNT_ADDR: rdata_d = day_q;
        MONTH_COUNT_ADDR:        rdata_d = month_q;
        default:                 rdata_d = READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_q <= READ_UNMAPPED;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata    = rdata_q;
  assign year_carry   = year_carry_q;
  assign day_of_month = day_q;
  assign month        = month_q;

endmodule // cdm_date_month

// ### rtl/cdm_pkg.sv
package cdm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DAY_OF_MONTH_COUNT_ADDR = 8'h04;
  localparam logic [7:0] MONTH_COUNT_ADDR        = 8'h05;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int DAY_UNITS_LSB   = 0;
  localparam int DAY_UNITS_MSB   = 3;
  localparam int DAY_TENS_LSB    = 4;
  localparam int DAY_TENS_MSB    = 5;
  localparam int MONTH_UNITS_LSB = 0;
  localparam int MONTH_UNITS_MSB = 3;
  localparam int MONTH_TENS_BIT  = 4;

  // bits that hold digits; everything else is reserved_bits and reads zero
  localparam logic [7:0] DAY_FIELD_MASK   = 8'h3f;
  localparam logic [7:0] MONTH_FIELD_MASK = 8'h1f;

  // ----------------------------------------------------------------
  // reset values and calendar constants (bcd)
  // ----------------------------------------------------------------
  localparam logic [7:0] DAY_RESET     = 8'h01;
  localparam logic [7:0] MONTH_RESET   = 8'h01;
  localparam logic [7:0] FIRST_DAY     = 8'h01;
  localparam logic [7:0] FIRST_MONTH   = 8'h01;
  localparam logic [7:0] LAST_MONTH    = 8'h12;
  localparam logic [7:0] MONTH_FEB     = 8'h02;
  localparam logic [7:0] MONTH_APR     = 8'h04;
  localparam logic [7:0] MONTH_JUN     = 8'h06;
  localparam logic [7:0] MONTH_SEP     = 8'h09;
  localparam logic [7:0] MONTH_NOV     = 8'h11;
  localparam logic [7:0] DAYS_28       = 8'h28;
  localparam logic [7:0] DAYS_29       = 8'h29;
  localparam logic [7:0] DAYS_30       = 8'h30;
  localparam logic [7:0] DAYS_31       = 8'h31;
  localparam logic [3:0] BCD_NINE      = 4'h9;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

endpackage : cdm_pkg
